/* ptm_core.sv */
// 10-bit periodic timer core: counter, comparators A and P, control regs
// assumes byte register port, sys clock CLK; high clock ticks from CLK_H_TICK
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Function
// - 10-bit up counter, selectable clock source
// - comparators A and P against counter
// - software clears counter only via on rising
// - auto clear on overflow or selected match
// - interrupt request on every match or overflow clear and on capture, not on the on-rising clear
// - pause bit holds counter, resumes later
// - clock select field picks count clock
// - on rising clears, falling keeps value
// - on cleared stops counter, powers down
// - compare mode: on rising restores initial level
// - mode field selects operating mode
// - timer/counter mode output fixed low
// - counter readable as low/high byte pair
// - compare A and P read/write byte pairs
// - control 0 bits 2..0 read zero
// - two input pins, two output pins
// - compare mode output function on A match
// - clear select picks A or P/overflow in compare and timer modes
// - output control bit sets initial/active level
// - polarity bit inverts output except timer mode
module ptm_core
   import ptm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic CLK_H_TICK,
   input wire logic TB_TICK,
   input wire logic EXT_CLK,
   input wire logic CAPTURE_IN,
   output logic OUT,
   output logic OUT_N,
   output logic IRQ,
   output logic POWER_ON
);
   import ptm_pkg::*;

   logic [7:0] ctrl0;
   logic [7:0] ctrl1;
   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] cmp_a;
   logic [CNT_W-1:0] cmp_p;
   logic on_d;
   logic [2:0] ext_sync;
   logic [1:0] cap_sync;
   logic [1:0] sys_div;
   logic [5:0] h_div;
   logic out_lvl;
   logic tick;
   logic on_rise;
   logic match_a;
   logic match_p;
   logic overflow;
   logic clear_now;
   logic counting;
   logic cap_edge;
   logic [1:0] mode;
   logic [1:0] outf;
   logic [2:0] cks;
   logic pwm_lvl;
   logic hit_a;
   logic hit_p;
   logic clear_by_a;

   assign mode = ctrl1[7:6];
   assign outf = ctrl1[5:4];
   assign cks = ctrl0[6:4];
   assign on_rise = ctrl0[CTRL0_ON_BIT] & ~on_d;
   assign counting = ctrl0[CTRL0_ON_BIT] & ~ctrl0[CTRL0_PAUSE_BIT];
   assign POWER_ON = ctrl0[CTRL0_ON_BIT];

   // register port
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl0 <= CTRL0_RESET;
         ctrl1 <= CTRL1_RESET;
      end else if (WR) begin
         if (ADDR == ADDR_CTRL0) begin
            ctrl0 <= WDATA & CTRL0_WMASK;
         end
         if (ADDR == ADDR_CTRL1) begin
            ctrl1 <= WDATA;
         end
      end
   end

   // capture into compare A wins over a same-cycle software write
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cmp_a <= '0;
         cmp_p <= '0;
      end else begin
         if (WR && ADDR == ADDR_CMPA_LO) begin
            cmp_a[7:0] <= WDATA;
         end
         if (WR && ADDR == ADDR_CMPA_HI) begin
            cmp_a[9:8] <= WDATA[1:0];
         end
         if (WR && ADDR == ADDR_CMPP_LO) begin
            cmp_p[7:0] <= WDATA;
         end
         if (WR && ADDR == ADDR_CMPP_HI) begin
            cmp_p[9:8] <= WDATA[1:0];
         end
         if (cap_edge) begin
            cmp_a <= count;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         unique case (ADDR)
            ADDR_CTRL0: RDATA <= ctrl0;
            ADDR_CTRL1: RDATA <= ctrl1;
            ADDR_CNT_LO: RDATA <= count[7:0];
            ADDR_CNT_HI: RDATA <= {6'h00, count[9:8]};
            ADDR_CMPA_LO: RDATA <= cmp_a[7:0];
            ADDR_CMPA_HI: RDATA <= {6'h00, cmp_a[9:8]};
            ADDR_CMPP_LO: RDATA <= cmp_p[7:0];
            ADDR_CMPP_HI: RDATA <= {6'h00, cmp_p[9:8]};
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // pins pass two flops; the third stage is only for edge detection
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ext_sync <= 3'h0;
         cap_sync <= 2'h0;
         on_d <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[1:0], EXT_CLK};
         cap_sync <= {cap_sync[0], CAPTURE_IN};
         on_d <= ctrl0[CTRL0_ON_BIT];
      end
   end

   logic cap_d;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cap_d <= 1'b0;
      end else begin
         cap_d <= ctrl1[1] ? ext_sync[1] : cap_sync[1];
      end
   end

   logic cap_now;
   assign cap_now = ctrl1[1] ? ext_sync[1] : cap_sync[1];
   always_comb begin
      cap_edge = 1'b0;
      if (mode == MODE_CAPTURE && ctrl0[CTRL0_ON_BIT]) begin
         unique case (outf)
            2'h0: cap_edge = cap_now & ~cap_d;
            2'h1: cap_edge = ~cap_now & cap_d;
            2'h2: cap_edge = cap_now ^ cap_d;
            2'h3: cap_edge = 1'b0;
         endcase
      end
   end

   // prescalers clear and stay at zero while off to save power
   always_ff @(posedge CLK) begin
      if (!RST_N || !ctrl0[CTRL0_ON_BIT]) begin
         sys_div <= 2'h0;
         h_div <= 6'h00;
      end else begin
         sys_div <= sys_div + 2'h1;
         if (CLK_H_TICK) begin
            h_div <= h_div + 6'h01;
         end
      end
   end

   always_comb begin
      unique case (cks)
         CKS_SYS4: tick = (sys_div == 2'h3);
         CKS_SYS: tick = 1'b1;
         CKS_H16: tick = CLK_H_TICK & (h_div[3:0] == 4'hf);
         CKS_H64: tick = CLK_H_TICK & (h_div == PRESC_MAX);
         CKS_TB0, CKS_TB1: tick = TB_TICK;
         CKS_EXT_RISE: tick = ext_sync[1] & ~ext_sync[2];
         CKS_EXT_FALL: tick = ~ext_sync[1] & ext_sync[2];
      endcase
   end

   assign match_a = (count == cmp_a);
   assign match_p = (count == cmp_p);
   assign overflow = (count == {CNT_W{1'b1}});
   // a zero compare value runs the counter to the top; letting it match
   // would pin a freshly cleared counter at zero
   assign hit_a = (cmp_a == '0) ? overflow : match_a;
   assign hit_p = (cmp_p == '0) ? overflow : match_p;
   // pwm and capture always clear on P
   assign clear_by_a = ctrl1[0] && mode != MODE_PWM && mode != MODE_CAPTURE;
   always_comb begin
      if (clear_by_a) begin
         clear_now = hit_a;
      end else begin
         clear_now = hit_p;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         count <= '0;
      end else if (on_rise) begin
         count <= '0;
      end else if (counting && tick) begin
         if (clear_now) begin
            count <= '0;
         end else begin
            count <= count + 10'h001;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= (counting && tick && clear_now && !on_rise) || cap_edge;
      end
   end

   // pwm level is active while count below duty value
   assign pwm_lvl = (count < cmp_a) ? ctrl1[3] : ~ctrl1[3];

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         out_lvl <= 1'b0;
      end else if (on_rise && mode == MODE_COMPARE) begin
         out_lvl <= ctrl1[3];
      end else if (mode == MODE_COMPARE && counting && tick && match_a && cmp_a != '0) begin
         unique case (outf)
            OUTF_NONE: out_lvl <= out_lvl;
            OUTF_LOW: out_lvl <= 1'b0;
            OUTF_HIGH: out_lvl <= 1'b1;
            OUTF_TOGGLE: out_lvl <= ~out_lvl;
         endcase
      end else if (mode == MODE_PWM) begin
         unique case (outf)
            2'h0: out_lvl <= ~ctrl1[3];
            2'h1: out_lvl <= ctrl1[3];
            default: out_lvl <= ctrl0[CTRL0_ON_BIT] ? pwm_lvl : ~ctrl1[3];
         endcase
      end else if (mode == MODE_TIMER) begin
         out_lvl <= 1'b0;
      end
   end

   // timer mode drives a fixed low; polarity ignored there
   always_comb begin
      if (mode == MODE_TIMER) begin
         OUT = 1'b0;
      end else begin
         OUT = out_lvl ^ ctrl1[2];
      end
      OUT_N = ~OUT;
   end

   // helper for the long-pause check: the value the counter must keep
   logic pause_d;
   logic [CNT_W-1:0] held_count;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pause_d <= 1'b0;
         held_count <= '0;
      end else begin
         pause_d <= ctrl0[CTRL0_PAUSE_BIT];
         if (on_rise) begin
            held_count <= '0;
         end else if (ctrl0[CTRL0_PAUSE_BIT] && !pause_d) begin
            held_count <= count;
         end
      end
   end

   a_on_rise_clears: assert property (@(posedge CLK) disable iff (!RST_N)
      on_rise |=> count == '0)
      else $error("count not cleared on enable");
   a_count_ro: assert property (@(posedge CLK) disable iff (!RST_N)
      WR && (ADDR == ADDR_CNT_LO || ADDR == ADDR_CNT_HI) && !counting && !on_rise
      |=> $stable(count))
      else $error("count changed by a write");
   a_pause_holds: assert property (@(posedge CLK) disable iff (!RST_N)
      ctrl0[CTRL0_PAUSE_BIT] && !on_rise |=> $stable(count))
      else $error("count moved in pause");
   a_pause_long: assert property (@(posedge CLK) disable iff (!RST_N)
      pause_d |-> count == held_count)
      else $error("count drifted during pause");
   a_off_holds: assert property (@(posedge CLK) disable iff (!RST_N)
      !ctrl0[CTRL0_ON_BIT] && on_d |=> $stable(count))
      else $error("count moved while off");
   a_off_frozen: assert property (@(posedge CLK) disable iff (!RST_N)
      !ctrl0[CTRL0_ON_BIT] |=> $stable(count))
      else $error("count moved in off state");

   a_clear_irq: assert property (@(posedge CLK) disable iff (!RST_N)
      counting && tick && clear_now && !on_rise |=> IRQ && count == '0)
      else $error("clear without irq");
   a_capture_irq: assert property (@(posedge CLK) disable iff (!RST_N)
      cap_edge |=> IRQ)
      else $error("capture without irq");
   a_count_step: assert property (@(posedge CLK) disable iff (!RST_N)
      counting && tick && !clear_now && !on_rise |=> count == $past(count) + 10'h001)
      else $error("bad increment");
   a_match_p_clears: assert property (@(posedge CLK) disable iff (!RST_N)
      counting && tick && !on_rise && !clear_by_a && cmp_p != '0 && match_p
      |=> count == '0 && IRQ)
      else $error("P match did not clear");
   a_match_a_clears: assert property (@(posedge CLK) disable iff (!RST_N)
      counting && tick && !on_rise && clear_by_a && cmp_a != '0 && match_a
      |=> count == '0 && IRQ)
      else $error("A match did not clear");
   a_zero_p_runs: assert property (@(posedge CLK) disable iff (!RST_N)
      counting && tick && !on_rise && !clear_by_a && cmp_p == '0 && count == '0
      |=> count == 10'h001)
      else $error("zero P stopped the count");
   a_overflow_wrap: assert property (@(posedge CLK) disable iff (!RST_N)
      counting && tick && !on_rise && !clear_by_a && cmp_p == '0 && overflow
      |=> count == '0 && IRQ)
      else $error("overflow did not clear");

   a_sys4_rate: assert property (@(posedge CLK) disable iff (!RST_N)
      cks == CKS_SYS4 && tick |=> !tick || cks != $past(cks))
      else $error("quarter clock ticked twice");
   a_ext_single: assert property (@(posedge CLK) disable iff (!RST_N)
      (cks == CKS_EXT_RISE || cks == CKS_EXT_FALL) && tick |=> !tick || cks != $past(cks))
      else $error("pin edge counted twice");

   a_ctrl0_low_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      ctrl0[2:0] == 3'h0)
      else $error("ctrl0 low bits set");
   a_ctrl1_write: assert property (@(posedge CLK) disable iff (!RST_N)
      WR && ADDR == ADDR_CTRL1 |=> ctrl1 == $past(WDATA))
      else $error("ctrl1 write lost");
   a_capture_latch: assert property (@(posedge CLK) disable iff (!RST_N)
      cap_edge |=> cmp_a == $past(count))
      else $error("capture did not latch count");
   a_init_level: assert property (@(posedge CLK) disable iff (!RST_N)
      on_rise && mode == MODE_COMPARE |=> out_lvl == $past(ctrl1[3]))
      else $error("bad init level");
   a_out_set: assert property (@(posedge CLK) disable iff (!RST_N)
      mode == MODE_COMPARE && counting && tick && !on_rise && match_a && cmp_a != '0
      && (outf == OUTF_LOW || outf == OUTF_HIGH) |=> out_lvl == $past(outf[1]))
      else $error("match did not set output");
   a_out_toggle: assert property (@(posedge CLK) disable iff (!RST_N)
      mode == MODE_COMPARE && counting && tick && !on_rise && match_a && cmp_a != '0
      && outf == OUTF_TOGGLE |=> out_lvl != $past(out_lvl))
      else $error("match did not toggle output");
   a_out_pair: assert property (@(posedge CLK) disable iff (!RST_N)
      OUT_N == ~OUT)
      else $error("output pair not complementary");
   a_cnt_read: assert property (@(posedge CLK) disable iff (!RST_N)
      RD && ADDR == ADDR_CNT_HI |=> RDATA[7:2] == 6'h00)
      else $error("count high not masked");
   a_cmp_hi_read: assert property (@(posedge CLK) disable iff (!RST_N)
      RD && (ADDR == ADDR_CMPA_HI || ADDR == ADDR_CMPP_HI) |=> RDATA[7:2] == 6'h00)
      else $error("compare high not masked");
   a_cmpp_write: assert property (@(posedge CLK) disable iff (!RST_N)
      WR && ADDR == ADDR_CMPP_LO |=> cmp_p[7:0] == $past(WDATA))
      else $error("compare P write lost");

   c_overflow: cover property (@(posedge CLK) disable iff (!RST_N) counting && tick && overflow);
   c_match_a: cover property (@(posedge CLK) disable iff (!RST_N) counting && tick && match_a);
   c_capture: cover property (@(posedge CLK) disable iff (!RST_N) cap_edge);
   c_ext_tick: cover property (@(posedge CLK) disable iff (!RST_N) cks == CKS_EXT_FALL && tick);
   c_pwm_period: cover property (@(posedge CLK) disable iff (!RST_N)
      mode == MODE_PWM && counting && tick && clear_now);
endmodule

/* ptm_pkg.sv */
// package for the 10-bit periodic timer core: register map, fields, modes
// assumes a byte-wide register port and a single system clock
package ptm_pkg;
   localparam int CNT_W = 10;
   localparam logic [2:0] ADDR_CTRL0 = 3'h0;
   localparam logic [2:0] ADDR_CTRL1 = 3'h1;
   localparam logic [2:0] ADDR_CNT_LO = 3'h2;
   localparam logic [2:0] ADDR_CNT_HI = 3'h3;
   localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
   localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
   localparam logic [2:0] ADDR_CMPP_LO = 3'h6;
   localparam logic [2:0] ADDR_CMPP_HI = 3'h7;
   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam int CTRL0_PAUSE_BIT = 7;
   localparam int CTRL0_ON_BIT = 3;
   localparam logic [7:0] CTRL0_WMASK = 8'hf8;
   localparam logic [1:0] MODE_COMPARE = 2'h0;
   localparam logic [1:0] MODE_CAPTURE = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TIMER = 2'h3;
   localparam logic [1:0] OUTF_NONE = 2'h0;
   localparam logic [1:0] OUTF_LOW = 2'h1;
   localparam logic [1:0] OUTF_HIGH = 2'h2;
   localparam logic [1:0] OUTF_TOGGLE = 2'h3;
   localparam logic [2:0] CKS_SYS4 = 3'h0;
   localparam logic [2:0] CKS_SYS = 3'h1;
   localparam logic [2:0] CKS_H16 = 3'h2;
   localparam logic [2:0] CKS_H64 = 3'h3;
   localparam logic [2:0] CKS_TB0 = 3'h4;
   localparam logic [2:0] CKS_TB1 = 3'h5;
   localparam logic [2:0] CKS_EXT_RISE = 3'h6;
   localparam logic [2:0] CKS_EXT_FALL = 3'h7;
   localparam logic [5:0] PRESC_MAX = 6'h3f;
endpackage

/* ptm_pin_model.sv */
// pin-side partner for the periodic timer: external clock and capture pins
// assumes the bench calls its tasks; edges are slow next to the system clock
`timescale 1ns/1ps
module ptm_pin_model (
   output logic ext_clk,
   output logic capture_in
);
   initial begin
      ext_clk = 1'b0;
      capture_in = 1'b0;
   end
   // edges far apart so the 2-flop synchroniser never merges two
   task pulse(input int k);
      repeat (k) begin
         #230 ext_clk = 1'b1;
         #230 ext_clk = 1'b0;
      end
   endtask
   task capture();
      #170 capture_in = 1'b1;
      #400 capture_in = 1'b0;
   endtask
endmodule

/* test_periodic_timer_10bit.sv */
// bench for the periodic timer core, with an integer model of the counter
// assumes the pin model partner and ticks driven only by this bench
`timescale 1ns/1ps
module test_periodic_timer_10bit;
   import ptm_pkg::*;
   logic CLK = 0, RST_N = 0, WR = 0, RD = 0, CLK_H_TICK = 0, TB_TICK = 0;
   logic [2:0] ADDR = 3'h0;
   logic [7:0] WDATA = 8'h00, RDATA, rv;
   logic OUT, OUT_N, IRQ, POWER_ON, EXT_CLK, CAPTURE_IN;
   int fails = 0, comparisons = 0, seed = 60, irqs = 0, per, lvl, pol, n, full, e;
   always #25 CLK = ~CLK;
   ptm_core uut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .CLK_H_TICK(CLK_H_TICK), .TB_TICK(TB_TICK), .EXT_CLK(EXT_CLK),
      .CAPTURE_IN(CAPTURE_IN), .OUT(OUT), .OUT_N(OUT_N), .IRQ(IRQ), .POWER_ON(POWER_ON));
   ptm_pin_model pins (.ext_clk(EXT_CLK), .capture_in(CAPTURE_IN));
   always @(posedge CLK) begin
      CLK_H_TICK <= 1'($random(seed));
      if (IRQ === 1'b1) irqs++;
   end
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task rd(input logic [2:0] a);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      #1 rv = RDATA;
   endtask
   task ticks(input int k);
      repeat (k) begin
         @(posedge CLK) TB_TICK <= 1'b1;
         @(posedge CLK) TB_TICK <= 1'b0;
      end
   endtask
   task chk_count(input int c);
      repeat (4) @(posedge CLK);
      rd(ADDR_CNT_LO);
      chk("count_low", {8'h00, rv}, 16'(c & 255));
      rd(ADDR_CNT_HI);
      chk("count_high", {8'h00, rv}, 16'(c >> 8));
   endtask
   task restart(input logic [7:0] c1, input logic [2:0] cks);
      wr(ADDR_CTRL0, 8'h00);
      wr(ADDR_CTRL1, c1);
      wr(ADDR_CTRL0, {1'b0, cks, 1'b1, 3'b000});
      irqs = 0;
   endtask
   task print_verdict();
      if (fails == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #2000000;
      fails++;
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      rd(ADDR_CTRL1);
      chk("ctrl1", {8'h00, rv}, 16'(CTRL1_RESET));
      chk("out_n", {15'h0, OUT_N}, 16'h1);
      wr(ADDR_CTRL0, 8'hff);
      rd(ADDR_CTRL0);
      chk("ctrl0", {8'h00, rv}, 16'h00f8);
      chk("power", {15'h0, POWER_ON}, 16'h1);
      for (int i = 4; i < 8; i++) begin
         e = $random(seed) & 255;
         wr(3'(i), 8'(e));
         rd(3'(i));
         chk("compare", {8'h00, rv}, 16'(i[0] ? e & 3 : e));
      end
      wr(ADDR_CNT_LO, 8'h5a);
      chk_count(0);
      for (int f = 0; f < 4; f++) begin
         per = 3 + ($random(seed) & 7);
         lvl = $random(seed) & 1;
         pol = $random(seed) & 1;
         wr(ADDR_CMPP_LO, 8'(per));
         wr(ADDR_CMPP_HI, 8'h00);
         wr(ADDR_CMPA_LO, 8'h02);
         wr(ADDR_CMPA_HI, 8'h00);
         restart({MODE_COMPARE, 2'(f), 1'(lvl), 1'(pol), 2'b00}, f[0] ? CKS_TB1 : CKS_TB0);
         repeat (3) @(posedge CLK);
         chk("out_init", {15'h0, OUT}, 16'(lvl ^ pol));
         n = $random(seed) & 31;
         ticks(n);
         chk_count(n % (per + 1));
         chk("irqs", 16'(irqs), 16'(n / (per + 1)));
         ticks(per + 1 - n % (per + 1));
         full = n / (per + 1) + 1;
         e = (f == 0) ? lvl : (f == 1) ? 0 : (f == 2) ? 1 : lvl ^ (full & 1);
         repeat (3) @(posedge CLK);
         chk("out", {14'h0, OUT, OUT_N}, 16'({1'(e ^ pol), 1'(1 ^ e ^ pol)}));
      end
      wr(ADDR_CMPP_LO, 8'h40);
      ticks(3);
      wr(ADDR_CTRL0, {1'b1, CKS_TB1, 1'b1, 3'b000});
      ticks(5);
      chk_count(3);
      wr(ADDR_CTRL0, {1'b0, CKS_TB1, 1'b1, 3'b000});
      ticks(2);
      chk_count(5);
      wr(ADDR_CTRL0, {1'b0, CKS_TB1, 1'b0, 3'b000});
      @(posedge CLK);
      chk("power", {15'h0, POWER_ON}, 16'h0);
      ticks(4);
      chk_count(5);
      wr(ADDR_CMPA_LO, 8'h04);
      restart({MODE_TIMER, 5'b00000, 1'b1}, CKS_TB0);
      chk_count(0);
      ticks(12);
      chk_count(2);
      chk("out_timer", {15'h0, OUT}, 16'h0);
      chk("irqs", 16'(irqs), 16'h2);
      wr(ADDR_CMPP_LO, 8'h00);
      restart({MODE_TIMER, 6'b000000}, CKS_TB0);
      ticks(1025);
      chk_count(1);
      chk("irqs", 16'(irqs), 16'h1);
      for (int k = 0; k < 2; k++) begin
         restart({MODE_TIMER, 6'b000000}, k ? CKS_EXT_FALL : CKS_EXT_RISE);
         pins.pulse(5 + k);
         chk_count(5 + k);
      end
      restart({MODE_CAPTURE, 6'b000000}, CKS_TB0);
      ticks(7);
      pins.capture();
      repeat (4) @(posedge CLK);
      rd(ADDR_CMPA_LO);
      chk("captured", {8'h00, rv}, 16'h0007);
      print_verdict();
   end
endmodule
